// >>> verilog/ppm_data_pin_mux.sv
// Parallel port data pin function select and pin state control.
//
// Behaviour
// - Strap sampled in reset; high makes low pins memory data, low reserves them.
// - Function fixed at reset release and never changes afterwards.
// - Strap high assigns upper pins to memory data 31:16, inputs after reset.
// - Low pins used as memory data are inputs on leaving reset.
// - Bus holders enabled at reset, later follow the software holder control.
// - Data pins high impedance while hold is requested.
// - In hold, memory clocks keep toggling unless their tristate bit is set.
// - Data pins high impedance in off mode.
// - Low data pins high impedance while reset input is low.
// - Strap low assigns upper pins to parallel I/O bits, inputs after reset.
`timescale 1ns/1ps
`default_nettype none
module ppm_data_pin_mux
  import ppm_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_function_strap_pin,
  input  wire logic                  i_hold_req_n,
  input  wire ppm_emu_t              i_emu,
  input  wire logic                  i_bus_holder_sw_en,
  input  wire logic [PPM_CLK_N-1:0]  i_clock_out_hold_tristate,
  input  wire logic [PPM_DATA_W-1:0] i_ext_mem_dout,
  input  wire logic                  i_ext_mem_oe,
  input  wire logic [PPM_HALF_W-1:0] i_parallel_io_dout,
  input  wire logic [PPM_HALF_W-1:0] i_parallel_io_oe,
  input  wire logic [PPM_DATA_W-1:0] i_pin_d,
  output ppm_pins_t                  o_pins,
  output logic [PPM_DATA_W-1:0]      o_bus_holder_en,
  output logic [PPM_DATA_W-1:0]      o_ext_mem_data,
  output logic [PPM_HALF_W-1:0]      o_parallel_io_bits,
  output logic                       o_func_ext_mem,
  output logic                       o_func_parallel_io,
  output logic [PPM_CLK_N-1:0]       o_memory_clock_output,
  output logic [PPM_CLK_N-1:0]       o_memory_clock_oe
);

  // ****************************************************************
  // Function selection
  // ****************************************************************
  logic      strap_sample_reg;
  ppm_func_t func_reg;
  logic      func_unset;
  logic      func_emif;

  // Strap follows the pin for as long as reset is seen low.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      strap_sample_reg <= i_function_strap_pin;
    end
  end

  // Function is chosen on the first edge after release and then frozen.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      func_reg <= PPM_FUNC_UNSET;
    end else begin
      case (func_reg)
        PPM_FUNC_UNSET: begin
          func_reg <= (strap_sample_reg == PPM_STRAP_EMIF) ? PPM_FUNC_EMIF : PPM_FUNC_GPIO;
        end
        PPM_FUNC_EMIF: func_reg <= PPM_FUNC_EMIF;
        PPM_FUNC_GPIO: func_reg <= PPM_FUNC_GPIO;
        default:       func_reg <= PPM_FUNC_UNSET;
      endcase
    end
  end

  assign func_unset         = (func_reg == PPM_FUNC_UNSET);
  assign func_emif          = (func_reg == PPM_FUNC_EMIF);
  assign o_func_ext_mem     = func_emif;
  assign o_func_parallel_io = (func_reg == PPM_FUNC_GPIO);

  // ****************************************************************
  // High impedance conditions
  // ****************************************************************
  logic off_mode;
  logic hold_active;
  logic force_z_low;
  logic force_z_high;

  assign off_mode     = !i_emu.test_rst_n && i_emu.emulation_pin_zero && !i_emu.emulation_pin_one_off;
  assign hold_active  = !i_hold_req_n;
  assign force_z_low  = !i_nrst || off_mode || hold_active || !func_emif;
  assign force_z_high = !i_nrst || off_mode || hold_active || func_unset;

  // ****************************************************************
  // Pin lanes
  // ****************************************************************
  logic [PPM_HALF_W-1:0] low_req;
  logic [PPM_HALF_W-1:0] high_req;
  logic [PPM_HALF_W-1:0] high_dout;
  logic [PPM_HALF_W-1:0] low_rx;
  logic [PPM_HALF_W-1:0] high_rx;
  logic [PPM_HALF_W-1:0] low_out;
  logic [PPM_HALF_W-1:0] low_oe;
  logic [PPM_HALF_W-1:0] high_out;
  logic [PPM_HALF_W-1:0] high_oe;

  assign low_req   = func_emif ? {PPM_HALF_W{i_ext_mem_oe}} : '0;
  assign high_req  = func_emif ? {PPM_HALF_W{i_ext_mem_oe}} : i_parallel_io_oe;
  assign high_dout = func_emif ? i_ext_mem_dout[PPM_DATA_W-1:PPM_HALF_W] : i_parallel_io_dout;

  ppm_pin_lane #(.W(PPM_HALF_W)) u_low_lane (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_dout      (i_ext_mem_dout[PPM_HALF_W-1:0]),
    .i_drive_req (low_req),
    .i_clear     (func_unset),
    .i_force_z   (force_z_low),
    .i_pin_in    (i_pin_d[PPM_HALF_W-1:0]),
    .o_pin_out   (low_out),
    .o_pin_oe    (low_oe),
    .o_rx        (low_rx)
  );

  ppm_pin_lane #(.W(PPM_HALF_W)) u_high_lane (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_dout      (high_dout),
    .i_drive_req (high_req),
    .i_clear     (func_unset),
    .i_force_z   (force_z_high),
    .i_pin_in    (i_pin_d[PPM_DATA_W-1:PPM_HALF_W]),
    .o_pin_out   (high_out),
    .o_pin_oe    (high_oe),
    .o_rx        (high_rx)
  );

  // Both lanes meet in the pin carrier.
  assign o_pins             = '{dout: {high_out, low_out}, oe: {high_oe, low_oe}};
  assign o_ext_mem_data     = {high_rx, low_rx};
  assign o_parallel_io_bits = high_rx;

  // ****************************************************************
  // Bus holders
  // ****************************************************************
  logic holder_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      holder_reg <= PPM_HOLDER_RST;
    end else begin
      holder_reg <= i_bus_holder_sw_en;
    end
  end

  assign o_bus_holder_en = {PPM_DATA_W{holder_reg}};

  // ****************************************************************
  // Memory clock outputs
  // ****************************************************************
  logic clk_div_reg;

  // Free running divide by two of the core clock.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_div_reg <= PPM_CLKDIV_RST;
    end else begin
      clk_div_reg <= !clk_div_reg;
    end
  end

  assign o_memory_clock_output = {PPM_CLK_N{clk_div_reg}};
  assign o_memory_clock_oe     = ~({PPM_CLK_N{hold_active}} & i_clock_out_hold_tristate);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_strap_choice: assert property (func_unset ##1 !func_unset |-> func_emif == $past(strap_sample_reg))
    else $error("Function does not match sampled strap.");
  a_func_frozen: assert property (!func_unset |=> $stable(func_reg))
    else $error("Function changed after release.");
  a_high_input_emif: assert property (func_unset ##1 func_emif |-> o_pins.oe[PPM_DATA_W-1:PPM_HALF_W] == '0)
    else $error("Upper pins driven on leaving reset.");
  a_low_input_emif: assert property (func_unset ##1 func_emif |-> o_pins.oe[PPM_HALF_W-1:0] == '0)
    else $error("Lower pins driven on leaving reset.");
  a_holder_reset: assert property ($rose(i_nrst) |-> o_bus_holder_en == '1 ##1
                                   o_bus_holder_en == {PPM_DATA_W{$past(i_bus_holder_sw_en)}})
    else $error("Bus holder enable wrong after reset.");
  a_hold_tristate: assert property (hold_active |-> o_pins.oe == '0)
    else $error("Data pins driven during hold.");
  a_clk_hold_run: assert property (hold_active && !i_clock_out_hold_tristate[0] ##1
                                   hold_active && !i_clock_out_hold_tristate[0]
                                   |-> o_memory_clock_oe[0] && $changed(o_memory_clock_output[0]))
    else $error("Memory clock not toggling in hold.");
  a_clk_run_upper: assert property (hold_active && !i_clock_out_hold_tristate[1] ##1
                                    hold_active && !i_clock_out_hold_tristate[1]
                                    |-> o_memory_clock_oe[1] && $changed(o_memory_clock_output[1]))
    else $error("Second memory clock not toggling in hold.");
  a_clk_hold_z: assert property (hold_active |-> (o_memory_clock_oe & i_clock_out_hold_tristate) == '0)
    else $error("Memory clock driven in hold with tristate set.");
  a_holder_follow: assert property (1'h1 |=> o_bus_holder_en == {PPM_DATA_W{$past(i_bus_holder_sw_en)}})
    else $error("Bus holder enable does not follow software.");
  a_gpio_drive: assert property (o_func_parallel_io && $past(o_func_parallel_io) && !hold_active
                                 && !off_mode |-> o_pins.oe[PPM_DATA_W-1:PPM_HALF_W] == $past(i_parallel_io_oe))
    else $error("Parallel I/O drive does not follow request.");
  a_off_tristate: assert property (off_mode |-> o_pins.oe == '0)
    else $error("Data pins driven in off mode.");
  a_low_z_reset: assert property (@(posedge i_clk) disable iff (1'h0) !i_nrst |-> o_pins.oe[PPM_HALF_W-1:0] == '0)
    else $error("Lower pins driven during reset.");
  a_gpio_select: assert property (func_unset ##1 o_func_parallel_io |-> !$past(strap_sample_reg)
                                  && o_pins.oe[PPM_DATA_W-1:PPM_HALF_W] == '0)
    else $error("Parallel I/O selection wrong.");
  a_reserved_quiet: assert property (!func_emif |-> o_pins.oe[PPM_HALF_W-1:0] == '0)
    else $error("Reserved pins driven.");

  c_emif_lock: cover property (func_unset ##1 func_emif);
  c_gpio_lock: cover property (func_unset ##1 o_func_parallel_io);
  c_hold_run:  cover property (hold_active && !i_clock_out_hold_tristate[0]);
  c_off_mode:  cover property (off_mode && func_emif);
  c_hold_z:    cover property (hold_active && i_clock_out_hold_tristate[1]);

endmodule : ppm_data_pin_mux
`default_nettype wire

// >>> verilog/ppm_pkg.sv
// Shared constants and types for the parallel port data pin multiplexer.
package ppm_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PPM_DATA_W = 32;
  localparam int PPM_HALF_W = 16;
  localparam int PPM_CLK_N  = 2;

  // ****************************************************************
  // Levels and reset values
  // ****************************************************************
  localparam logic PPM_STRAP_EMIF   = 1'h1;
  localparam logic PPM_HOLDER_RST   = 1'h1;
  localparam logic PPM_CLKDIV_RST   = 1'h0;
  localparam logic PPM_LANE_OE_RST  = 1'h0;
  localparam logic PPM_LANE_DAT_RST = 1'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PPM_FUNC_UNSET,
    PPM_FUNC_EMIF,
    PPM_FUNC_GPIO
  } ppm_func_t;

  typedef struct packed {
    logic test_rst_n;
    logic emulation_pin_zero;
    logic emulation_pin_one_off;
  } ppm_emu_t;

  typedef struct packed {
    logic [PPM_DATA_W-1:0] dout;
    logic [PPM_DATA_W-1:0] oe;
  } ppm_pins_t;

endpackage : ppm_pkg

// >>> verilog/ppm_pin_lane.sv
// One group of data pins: registered drive data, enable and input capture.
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_lane
  import ppm_pkg::*;
#(
  parameter int W = PPM_HALF_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_dout,
  input  wire logic [W-1:0] i_drive_req,
  input  wire logic         i_clear,
  input  wire logic         i_force_z,
  input  wire logic [W-1:0] i_pin_in,
  output logic      [W-1:0] o_pin_out,
  output logic      [W-1:0] o_pin_oe,
  output logic      [W-1:0] o_rx
);

  logic [W-1:0] out_reg;
  logic [W-1:0] oe_reg;
  logic [W-1:0] rx_reg;

  // Drive data register.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_reg <= {W{PPM_LANE_DAT_RST}};
    end else begin
      out_reg <= i_dout;
    end
  end

  // Enable register, held clear until the function is fixed.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      oe_reg <= {W{PPM_LANE_OE_RST}};
    end else if (i_clear) begin
      oe_reg <= {W{PPM_LANE_OE_RST}};
    end else begin
      oe_reg <= i_drive_req;
    end
  end

  // Input capture register.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_reg <= {W{PPM_LANE_DAT_RST}};
    end else begin
      rx_reg <= i_pin_in;
    end
  end

  assign o_pin_out = out_reg;
  assign o_pin_oe  = i_force_z ? {W{PPM_LANE_OE_RST}} : oe_reg;
  assign o_rx      = rx_reg;

endmodule : ppm_pin_lane
`default_nettype wire

// >>> verif/ppm_mem_model.sv
// Behavioural external memory sitting on the parallel data bus.
`timescale 1ns/1ps
`default_nettype none
module ppm_mem_model
  import ppm_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire ppm_pins_t             i_pins,
  input  wire logic [PPM_DATA_W-1:0] i_holder_en,
  input  wire logic                  i_mem_oe,
  input  wire logic [PPM_DATA_W-1:0] i_mem_dout,
  output logic      [PPM_DATA_W-1:0] o_bus
);
  logic [PPM_DATA_W-1:0] last_reg = '0;
  // Undriven bits keep their level with a holder and flip every cycle without one.
  always_comb begin
    for (int i = 0; i < PPM_DATA_W; i++) begin
      if (i_pins.oe[i]) o_bus[i] = i_pins.dout[i];
      else if (i_mem_oe) o_bus[i] = i_mem_dout[i];
      else if (i_holder_en[i]) o_bus[i] = last_reg[i];
      else o_bus[i] = ~last_reg[i];
    end
  end
  always_ff @(posedge i_clk) last_reg <= o_bus;
endmodule : ppm_mem_model
`default_nettype wire

// >>> verif/ppm_data_pin_mux_tb.sv
// Self-checking testbench for the parallel port data pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
module ppm_data_pin_mux_tb;
  import ppm_pkg::*;
  logic clk, nrst, strap, hold_n, hsw, emoe, mem_oe, fe, fg;
  ppm_emu_t emu;
  ppm_pins_t pins;
  logic [1:0] ckz, mck, mckoe;
  logic [15:0] gpd, gpoe, gpbits;
  logic [31:0] emd, pind, hen, emdata, mem_d;
  int num_errors = 0;
  int checked = 0;

  ppm_data_pin_mux DUT (.i_clk(clk), .i_nrst(nrst), .i_function_strap_pin(strap), .i_hold_req_n(hold_n),
    .i_emu(emu), .i_bus_holder_sw_en(hsw), .i_clock_out_hold_tristate(ckz), .i_ext_mem_dout(emd),
    .i_ext_mem_oe(emoe), .i_parallel_io_dout(gpd), .i_parallel_io_oe(gpoe), .i_pin_d(pind), .o_pins(pins),
    .o_bus_holder_en(hen), .o_ext_mem_data(emdata), .o_parallel_io_bits(gpbits), .o_func_ext_mem(fe),
    .o_func_parallel_io(fg), .o_memory_clock_output(mck), .o_memory_clock_oe(mckoe));
  ppm_mem_model MEM (.i_clk(clk), .i_pins(pins), .i_holder_en(hen), .i_mem_oe(mem_oe),
    .i_mem_dout(mem_d), .o_bus(pind));

  always #4 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic report_and_stop;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    nrst = 0; strap = 1; emoe = 1; emd = 32'ha5c3_1e69; cyc(16);
    chk(pins.oe, 32'h0, "oe in reset");
    chk(hen, 32'hffff_ffff, "holders in reset");
    chk({fe, fg}, 32'h0, "func in reset");
    nrst = 1; strap = 0; cyc(1);
    chk({fe, fg}, 32'h2, "func memory");
    chk(pins.oe, 32'h0, "inputs after reset");
    chk(hen, 32'h0, "holders follow sw");
    cyc(3);
    chk({fe, fg}, 32'h2, "func kept");
    chk(pins.oe, 32'hffff_ffff, "memory drives");
    chk(pins.dout, emd, "memory data");
    hsw = 1; cyc(1);
    chk(hen, 32'hffff_ffff, "holders on");
    $display("test reset done");
  endtask : t_reset

  task automatic t_read;
    emoe = 0; cyc(1); mem_oe = 1; mem_d = 32'h3c96_0ff1; cyc(1);
    chk(emdata, mem_d, "read capture");
    mem_oe = 0;
    $display("test read done");
  endtask : t_read

  task automatic t_hold;
    logic [1:0] p;
    emoe = 1; ckz = 2'h2; cyc(2); hold_n = 0; #1;
    chk(pins.oe, 32'h0, "oe in hold");
    chk(mckoe, 32'h1, "clock float");
    p = ~mck; cyc(1);
    chk(mck, p, "clock runs in hold");
    cyc(1); ckz = 2'h1; #1;
    chk(mckoe, 32'h2, "other clock float");
    cyc(2); hold_n = 1; cyc(2);
    chk(pins.oe, 32'hffff_ffff, "oe after hold");
    chk(mckoe, 32'h3, "clock driven");
    $display("test hold done");
  endtask : t_hold

  task automatic t_off;
    emu = 3'h2; #1;
    chk(pins.oe, 32'h0, "oe in off");
    emu = 3'h6; cyc(2);
    chk(pins.oe, 32'hffff_ffff, "oe not off");
    emu = 3'h7;
    $display("test off done");
  endtask : t_off

  task automatic t_gpio;
    gpoe = 16'h00ff; gpd = 16'h5a3c; nrst = 0; strap = 0; cyc(16); nrst = 1; strap = 1; cyc(3);
    chk({fe, fg}, 32'h1, "func gpio");
    chk(pins.oe, 32'h00ff_0000, "reserved undriven");
    chk(pins.dout[31:16], gpd, "gpio data");
    gpoe = 0; mem_oe = 1; mem_d = 32'h9e37_4b21; cyc(2);
    chk(gpbits, mem_d[31:16], "gpio capture");
    mem_oe = 0;
    $display("test gpio done");
  endtask : t_gpio

  initial begin
    clk = 0; nrst = 0; strap = 1; hold_n = 1; emu = 3'h7; hsw = 0; ckz = 2'h0;
    emd = 0; emoe = 0; gpd = 0; gpoe = 0; mem_oe = 0; mem_d = 0;
    t_reset();
    t_read();
    t_hold();
    t_off();
    t_gpio();
    report_and_stop();
  end

  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule : ppm_data_pin_mux_tb
`default_nettype wire
